// File: pmops_cfg.svh
// Register offsets, field positions, reset values and masks of the output stage
`ifndef PMOPS_CFG_SVH
`define PMOPS_CFG_SVH

`define PMOPS_CHANNELS 16
`define PMOPS_ADDR_W 12

`define PMOPS_OFS_POL_A 12'h000
`define PMOPS_OFS_POL_B 12'h004
`define PMOPS_OFS_ROUTE_A 12'h008
`define PMOPS_OFS_ROUTE_B 12'h00c
`define PMOPS_OFS_PERIPHERAL_CLOCK_SELECT 12'h010
`define PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG 12'h014
`define PMOPS_OFS_DUTY 12'h018
`define PMOPS_OFS_DIR1 12'h01c
`define PMOPS_OFS_DIR2 12'h020
`define PMOPS_OFS_LATCH1 12'h024
`define PMOPS_OFS_LATCH2 12'h028
`define PMOPS_OFS_MODE 12'h02c

`define PMOPS_RST_BYTE 8'h00
`define PMOPS_PERIPHERAL_CLOCK_SELECT_WMASK 8'hf7
`define PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_WMASK 8'hcf
`define PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_ONES 8'h20
`define PMOPS_MODE_WMASK 8'h03

`define PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_CKE 7
`define PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_CKS 6
`define PMOPS_PERIPHERAL_CLOCK_SELECT_CKB 2
`define PMOPS_PERIPHERAL_CLOCK_SELECT_CKA 1
`define PMOPS_MODE_EXT 0
`define PMOPS_MODE_IO_SELECT_BIT 1
`define PMOPS_PORT_HI_FIRST 12

`endif

// File: pmops_pkg.sv
// Types shared by the output stage modules
package pmops_pkg;

    typedef enum logic [0:0] {
        PMOPS_APB_SETUP = 1'b0,
        PMOPS_APB_ACCESS = 1'b1
    } pmops_apb_state_type;

    typedef struct packed {
        logic polarity;
        logic route;
        logic direction;
        logic latch;
        logic port_ok;
    } pmops_chan_cfg_type;

    typedef struct packed {
        logic drive;
        logic enable;
    } pmops_pin_type;

endpackage : pmops_pkg

// File: pmops_chan.sv
// One channel: waveform from the shared counter, polarity and pin selection
`timescale 1ns/1ps
`include "pmops_cfg.svh"

module pmops_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] count,
    input wire logic [7:0] duty,
    input wire pmops_pkg::pmops_chan_cfg_type cfg,
    output pmops_pkg::pmops_pin_type pin
);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    pmops_pkg::pmops_pin_type next_pin;
    logic [3:0] slot;
    logic [3:0] pos;
    logic [3:0] upper;
    logic [3:0] lower;
    logic [3:0] rank;
    logic [4:0] sum;
    logic basic;
    logic added;
    logic level;

    always_comb begin
        slot = count[7:4];
        pos = count[3:0];
        upper = duty[7:4];
        lower = duty[3:0];
        // Basic pulse sits at the end of its slot, high for upper sixteenths
        sum = {1'b0, pos} + {1'b0, upper};
        basic = sum[4];
        // Spreading order of added pulses is the bit reverse of the slot from the end
        rank = {~slot[0], ~slot[1], ~slot[2], ~slot[3]};
        added = (pos == ~upper) && (rank < lower);
        level = (basic | added) ^ cfg.polarity;
        next_pin.drive = 1'b0;
        next_pin.enable = 1'b0;
        if (cfg.direction) begin
            if (cfg.route) begin
                next_pin.drive = level;
                next_pin.enable = 1'b1;
            end else if (cfg.port_ok) begin
                next_pin.drive = cfg.latch;
                next_pin.enable = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= '0;
        end else if (ce) begin
            pin <= next_pin;
        end
    end

    chk_input_release: assert property (
        ce && !cfg.direction |=> !pin.enable)
        else $error("pin driven while set as port input");

    chk_port_latch: assert property (
        ce && cfg.direction && !cfg.route && cfg.port_ok |=> pin.enable && pin.drive == $past(cfg.latch))
        else $error("port output does not show the latch");

    chk_zero_duty: assert property (
        ce && cfg.direction && cfg.route && duty == 8'h00 |=> pin.drive == $past(cfg.polarity))
        else $error("zero duty level wrong for polarity");

    chk_full_basic: assert property (
        ce && cfg.direction && cfg.route && duty[7:4] == 4'hf && count[3:0] != 4'h0
        |=> pin.drive == !$past(cfg.polarity))
        else $error("full basic pulse level wrong for polarity");

endmodule : pmops_chan

// File: pmops_top.sv
// Modulator output stage: APB registers, count clock, sixteen channels
`timescale 1ns/1ps
`include "pmops_cfg.svh"

module pmops_top (
    input wire logic clk,
    input wire logic ce,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PMOPS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] modulator_pins,
    output logic [15:0] modulator_pins_oe,
    output logic [15:0] address_bus_owned
);

    logic rst_meta;
    logic rst_n;

    // Asynchronous assert, release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] polarity_select_group_a;
    logic [7:0] polarity_select_group_b;
    logic [7:0] output_route_group_a;
    logic [7:0] output_route_group_b;
    logic [7:0] peripheral_clock_select;
    logic [7:0] channel_and_clock_select_reg;
    logic [7:0] port1_direction_bits;
    logic [7:0] port2_direction_bits;
    logic [7:0] port_output_latch_1;
    logic [7:0] port_output_latch_2;
    logic [7:0] system_control_reg;
    logic [7:0] duty_value_reg [`PMOPS_CHANNELS];
    pmops_pkg::pmops_apb_state_type apb_state;

    logic [7:0] next_polarity_select_group_a;
    logic [7:0] next_polarity_select_group_b;
    logic [7:0] next_output_route_group_a;
    logic [7:0] next_output_route_group_b;
    logic [7:0] next_peripheral_clock_select;
    logic [7:0] next_channel_and_clock_select_reg;
    logic [7:0] next_port1_direction_bits;
    logic [7:0] next_port2_direction_bits;
    logic [7:0] next_port_output_latch_1;
    logic [7:0] next_port_output_latch_2;
    logic [7:0] next_system_control_reg;
    logic [7:0] next_duty_value_reg [`PMOPS_CHANNELS];
    pmops_pkg::pmops_apb_state_type next_apb_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    logic [7:0] read_byte;
    logic addr_hit;
    logic [3:0] duty_index;

    assign duty_index = channel_and_clock_select_reg[3:0];

    always_comb begin
        read_byte = 8'h00;
        addr_hit = 1'b1;
        case (paddr)
            `PMOPS_OFS_POL_A: read_byte = polarity_select_group_a;
            `PMOPS_OFS_POL_B: read_byte = polarity_select_group_b;
            `PMOPS_OFS_ROUTE_A: read_byte = output_route_group_a;
            `PMOPS_OFS_ROUTE_B: read_byte = output_route_group_b;
            `PMOPS_OFS_PERIPHERAL_CLOCK_SELECT: read_byte = peripheral_clock_select;
            `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG: read_byte = channel_and_clock_select_reg | `PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_ONES;
            `PMOPS_OFS_DUTY: read_byte = duty_value_reg[duty_index];
            `PMOPS_OFS_DIR1: read_byte = port1_direction_bits;
            `PMOPS_OFS_DIR2: read_byte = port2_direction_bits;
            `PMOPS_OFS_LATCH1: read_byte = port_output_latch_1;
            `PMOPS_OFS_LATCH2: read_byte = port_output_latch_2;
            `PMOPS_OFS_MODE: read_byte = system_control_reg;
            default: addr_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_polarity_select_group_a = polarity_select_group_a;
        next_polarity_select_group_b = polarity_select_group_b;
        next_output_route_group_a = output_route_group_a;
        next_output_route_group_b = output_route_group_b;
        next_peripheral_clock_select = peripheral_clock_select;
        next_channel_and_clock_select_reg = channel_and_clock_select_reg;
        next_port1_direction_bits = port1_direction_bits;
        next_port2_direction_bits = port2_direction_bits;
        next_port_output_latch_1 = port_output_latch_1;
        next_port_output_latch_2 = port_output_latch_2;
        next_system_control_reg = system_control_reg;
        next_duty_value_reg = duty_value_reg;
        next_apb_state = apb_state;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        unique case (apb_state)
            pmops_pkg::PMOPS_APB_SETUP: begin
                // Answer is prepared in setup so pready comes from a flop
                if (psel && !penable) begin
                    next_pready = 1'b1;
                    next_pslverr = !addr_hit;
                    next_prdata = {24'h000000, read_byte};
                    next_apb_state = pmops_pkg::PMOPS_APB_ACCESS;
                end
            end
            pmops_pkg::PMOPS_APB_ACCESS: begin
                next_apb_state = pmops_pkg::PMOPS_APB_SETUP;
                if (psel && penable && pwrite && addr_hit) begin
                    case (paddr)
                        `PMOPS_OFS_POL_A: next_polarity_select_group_a = pwdata[7:0];
                        `PMOPS_OFS_POL_B: next_polarity_select_group_b = pwdata[7:0];
                        `PMOPS_OFS_ROUTE_A: next_output_route_group_a = pwdata[7:0];
                        `PMOPS_OFS_ROUTE_B: next_output_route_group_b = pwdata[7:0];
                        `PMOPS_OFS_PERIPHERAL_CLOCK_SELECT: begin
                            next_peripheral_clock_select = pwdata[7:0] & `PMOPS_PERIPHERAL_CLOCK_SELECT_WMASK;
                        end
                        `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG: begin
                            next_channel_and_clock_select_reg = pwdata[7:0] & `PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_WMASK;
                        end
                        `PMOPS_OFS_DUTY: next_duty_value_reg[duty_index] = pwdata[7:0];
                        `PMOPS_OFS_DIR1: next_port1_direction_bits = pwdata[7:0];
                        `PMOPS_OFS_DIR2: next_port2_direction_bits = pwdata[7:0];
                        `PMOPS_OFS_LATCH1: next_port_output_latch_1 = pwdata[7:0];
                        `PMOPS_OFS_LATCH2: next_port_output_latch_2 = pwdata[7:0];
                        `PMOPS_OFS_MODE: begin
                            next_system_control_reg = pwdata[7:0] & `PMOPS_MODE_WMASK;
                        end
                        default: next_prdata = prdata;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            polarity_select_group_a <= `PMOPS_RST_BYTE;
            polarity_select_group_b <= `PMOPS_RST_BYTE;
            output_route_group_a <= `PMOPS_RST_BYTE;
            output_route_group_b <= `PMOPS_RST_BYTE;
            peripheral_clock_select <= `PMOPS_RST_BYTE;
            channel_and_clock_select_reg <= `PMOPS_RST_BYTE;
            port1_direction_bits <= `PMOPS_RST_BYTE;
            port2_direction_bits <= `PMOPS_RST_BYTE;
            port_output_latch_1 <= `PMOPS_RST_BYTE;
            port_output_latch_2 <= `PMOPS_RST_BYTE;
            system_control_reg <= `PMOPS_RST_BYTE;
            for (int i = 0; i < `PMOPS_CHANNELS; i++) begin
                duty_value_reg[i] <= `PMOPS_RST_BYTE;
            end
            apb_state <= pmops_pkg::PMOPS_APB_SETUP;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            polarity_select_group_a <= next_polarity_select_group_a;
            polarity_select_group_b <= next_polarity_select_group_b;
            output_route_group_a <= next_output_route_group_a;
            output_route_group_b <= next_output_route_group_b;
            peripheral_clock_select <= next_peripheral_clock_select;
            channel_and_clock_select_reg <= next_channel_and_clock_select_reg;
            port1_direction_bits <= next_port1_direction_bits;
            port2_direction_bits <= next_port2_direction_bits;
            port_output_latch_1 <= next_port_output_latch_1;
            port_output_latch_2 <= next_port_output_latch_2;
            system_control_reg <= next_system_control_reg;
            duty_value_reg <= next_duty_value_reg;
            apb_state <= next_apb_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Count clock: prescaler and shared 8-bit counter
    logic [3:0] prescale;
    logic [7:0] count;
    logic [3:0] next_prescale;
    logic [7:0] next_count;
    logic [3:0] div_mask;
    logic count_clock_enable;
    logic count_clock_select;
    logic [1:0] clock_prescale;
    logic tick;

    always_comb begin
        count_clock_enable = channel_and_clock_select_reg[`PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_CKE];
        count_clock_select = channel_and_clock_select_reg[`PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_CKS];
        clock_prescale = {peripheral_clock_select[`PMOPS_PERIPHERAL_CLOCK_SELECT_CKB],
                          peripheral_clock_select[`PMOPS_PERIPHERAL_CLOCK_SELECT_CKA]};
        unique case (clock_prescale)
            2'h0: div_mask = 4'h1;
            2'h1: div_mask = 4'h3;
            2'h2: div_mask = 4'h7;
            2'h3: div_mask = 4'hf;
        endcase
        tick = count_clock_enable && (!count_clock_select || (prescale & div_mask) == div_mask);
        next_prescale = count_clock_enable ? prescale + 4'h1 : 4'h0;
        next_count = tick ? count + 8'h01 : count;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 4'h0;
            count <= 8'h00;
        end else if (ce) begin
            prescale <= next_prescale;
            count <= next_count;
        end
    end

    // Channels and pin selection
    logic [15:0] polarity_all;
    logic [15:0] route_all;
    logic [15:0] direction_all;
    logic [15:0] latch_all;
    logic [15:0] port_ok_all;
    logic [15:0] next_address_bus_owned;

    assign polarity_all = {polarity_select_group_b, polarity_select_group_a};
    assign route_all = {output_route_group_b, output_route_group_a};
    assign direction_all = {port2_direction_bits, port1_direction_bits};
    assign latch_all = {port_output_latch_2, port_output_latch_1};

    generate
        for (genvar g = 0; g < `PMOPS_CHANNELS; g++) begin : gen_chan
            pmops_pkg::pmops_chan_cfg_type cfg;
            pmops_pkg::pmops_pin_type pin;
            // Extended mode leaves only the top four pins to the port, and only with the I/O select bit set
            assign port_ok_all[g] = !system_control_reg[`PMOPS_MODE_EXT]
                || (system_control_reg[`PMOPS_MODE_IO_SELECT_BIT] && g >= `PMOPS_PORT_HI_FIRST);
            assign cfg.polarity = polarity_all[g];
            assign cfg.route = route_all[g];
            assign cfg.direction = direction_all[g];
            assign cfg.latch = latch_all[g];
            assign cfg.port_ok = port_ok_all[g];
            assign next_address_bus_owned[g] = direction_all[g] && !route_all[g] && !port_ok_all[g];
            assign modulator_pins[g] = pin.drive;
            assign modulator_pins_oe[g] = pin.enable;
            pmops_chan u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .count(count),
                .duty(duty_value_reg[g]),
                .cfg(cfg),
                .pin(pin)
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            address_bus_owned <= 16'h0000;
        end else if (ce) begin
            address_bus_owned <= next_address_bus_owned;
        end
    end

    chk_apb_answer: assert property (
        ce && psel && !penable && apb_state == pmops_pkg::PMOPS_APB_SETUP |=> pready)
        else $error("setup cycle not answered next cycle");

    chk_polarity_write: assert property (
        ce && psel && penable && pwrite && pready && paddr == `PMOPS_OFS_POL_A
        |=> polarity_select_group_a == $past(pwdata[7:0]))
        else $error("polarity group a write lost");

    chk_route_write: assert property (
        ce && psel && penable && pwrite && pready && paddr == `PMOPS_OFS_ROUTE_B
        |=> output_route_group_b == $past(pwdata[7:0]))
        else $error("route group b write lost");

    chk_clock_off: assert property (
        !count_clock_enable |=> $stable(count))
        else $error("counter moved with count clock off");

    chk_div16_spacing: assert property (
        ce && tick && count_clock_select && clock_prescale == 2'h3 && $stable(ce)
        ##1 ce && $stable(channel_and_clock_select_reg) && $stable(peripheral_clock_select)
        |-> !tick)
        else $error("divide by sixteen ticked on two cycles running");

    chk_port_window: assert property (
        ce && system_control_reg[`PMOPS_MODE_EXT] && port1_direction_bits[0] && !output_route_group_a[0]
        |=> !modulator_pins_oe[0] && address_bus_owned[0])
        else $error("low channel port output allowed in extended mode");

endmodule : pmops_top

// File: pmops_load.sv
// Pin load model: pull-down filter node that integrates high time per pin
`timescale 1ns/1ps

module pmops_load (
    input wire logic clk,
    input wire logic [15:0] pins,
    input wire logic [15:0] pins_oe,
    input wire logic start,
    input wire logic [12:0] window,
    output logic done,
    output logic [207:0] hi_cnt
);
    logic [12:0] left = 13'h0000;
    logic [15:0] node;

    // Released pin is discharged by the filter resistor, never holds its last level
    assign node = pins & pins_oe;

    initial begin
        done = 1'b0;
        hi_cnt = '0;
    end

    always @(posedge clk) begin
        done <= 1'b0;
        if (start) begin
            left <= window;
            hi_cnt <= '0;
        end else if (left != 13'h0000) begin
            left <= left - 13'h0001;
            done <= (left == 13'h0001);
            for (int i = 0; i < 16; i++) begin
                hi_cnt[i*13 +: 13] <= hi_cnt[i*13 +: 13] + {12'h000, node[i]};
            end
        end
    end
endmodule : pmops_load

// File: pmops_top_test.sv
// Self-checking bench: register access, polarity, pin routing and count clock
`timescale 1ns/1ps
`include "pmops_cfg.svh"

module pmops_top_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pins;
    logic [15:0] pins_oe;
    logic [15:0] owned;
    logic start = 1'b0;
    logic [12:0] window = 13'h0100;
    logic done;
    logic [207:0] hi_cnt;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [9:0] q_apb[$];
    logic [239:0] q_pin[$];
    logic [9:0] ea;
    logic [239:0] ep;
    logic [7:0] duty [16];
    logic [15:0] pol, dir, route, latch;
    logic [1:0] mode, pair;
    logic cks;
    int div;
    logic [11:0] ofs [12] = '{`PMOPS_OFS_POL_A, `PMOPS_OFS_POL_B, `PMOPS_OFS_ROUTE_A,
        `PMOPS_OFS_ROUTE_B, `PMOPS_OFS_PERIPHERAL_CLOCK_SELECT, `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG, `PMOPS_OFS_DUTY,
        `PMOPS_OFS_DIR1, `PMOPS_OFS_DIR2, `PMOPS_OFS_LATCH1, `PMOPS_OFS_LATCH2,
        `PMOPS_OFS_MODE};

    always #10 clk = ~clk;

    pmops_top DUT (.clk(clk), .ce(1'b1), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modulator_pins(pins), .modulator_pins_oe(pins_oe),
        .address_bus_owned(owned));
    pmops_load LOAD (.clk(clk), .pins(pins), .pins_oe(pins_oe), .start(start),
        .window(window), .done(done), .hi_cnt(hi_cnt));

    task automatic check(input logic [207:0] seen, input logic [207:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] exp, input logic err);
        int n;
        n = 0;
        q_apb.push_back({~wr, err, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic configure;
        apb(1'b1, `PMOPS_OFS_POL_A, pol[7:0], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_POL_B, pol[15:8], 8'h00, 1'b0);
        // Latch first: the pin shows it as soon as the route bit clears
        apb(1'b1, `PMOPS_OFS_LATCH1, latch[7:0], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_LATCH2, latch[15:8], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_DIR1, dir[7:0], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_DIR2, dir[15:8], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_MODE, {6'h00, mode}, 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_ROUTE_A, route[7:0], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_ROUTE_B, route[15:8], 8'h00, 1'b0);
        apb(1'b1, `PMOPS_OFS_PERIPHERAL_CLOCK_SELECT, {5'h00, pair, 1'b0}, 8'h00, 1'b0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG, {1'b1, cks, 2'b00, 4'(i)}, 8'h00, 1'b0);
            apb(1'b1, `PMOPS_OFS_DUTY, duty[i], 8'h00, 1'b0);
        end
        div = cks ? (2 << pair) : 1;
    endtask : configure

    task automatic measure;
        logic [207:0] c;
        logic [15:0] oe_e, own_e;
        logic ok;
        int cnt, n;
        for (int i = 0; i < 16; i++) begin
            ok = !mode[`PMOPS_MODE_EXT] || (i >= `PMOPS_PORT_HI_FIRST && mode[`PMOPS_MODE_IO_SELECT_BIT]);
            oe_e[i] = dir[i] && (route[i] || ok);
            own_e[i] = dir[i] && !route[i] && !ok;
            if (!oe_e[i]) cnt = 0;
            else if (route[i]) cnt = (pol[i] ? 256 - int'(duty[i]) : int'(duty[i])) * div;
            else cnt = latch[i] ? 256 * div : 0;
            c[i*13 +: 13] = 13'(cnt);
        end
        window <= 13'(256 * div);
        repeat (256 * div) @(posedge clk);
        q_pin.push_back({c, oe_e, own_e});
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 5000);
        if (n >= 5000) n_mismatch++;
        @(posedge clk);
    endtask : measure

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && q_apb.size() > 0) begin
            ea = q_apb.pop_front();
            check({207'h0, pslverr}, {207'h0, ea[8]});
            if (ea[9]) check({176'h0, prdata}, {200'h0, ea[7:0]});
        end
        if (done === 1'b1 && q_pin.size() > 0) begin
            ep = q_pin.pop_front();
            check(hi_cnt, ep[239:32]);
            check({192'h0, pins_oe}, {192'h0, ep[31:16]});
            check({192'h0, owned}, {192'h0, ep[15:0]});
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        logic [7:0] v, m;
        void'($urandom(76));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 12; i++) apb(1'b0, ofs[i], 8'h00, ofs[i] == `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG ? 8'h20 : 8'h00, 1'b0);
        apb(1'b1, 12'h030, 8'h5a, 8'h00, 1'b1);
        apb(1'b0, 12'h030, 8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom);
            m = ofs[i] == `PMOPS_OFS_PERIPHERAL_CLOCK_SELECT ? `PMOPS_PERIPHERAL_CLOCK_SELECT_WMASK : ofs[i] == `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG ?
                `PMOPS_CHANNEL_AND_CLOCK_SELECT_REG_WMASK : ofs[i] == `PMOPS_OFS_MODE ? `PMOPS_MODE_WMASK : 8'hff;
            apb(1'b1, ofs[i], v, 8'h00, 1'b0);
            apb(1'b0, ofs[i], 8'h00, (v & m) | (ofs[i] == `PMOPS_OFS_CHANNEL_AND_CLOCK_SELECT_REG ? 8'h20 : 8'h00), 1'b0);
        end
        // Polarity and duty with boundary values
        for (int i = 0; i < 16; i++) duty[i] = 8'($urandom);
        duty[0] = 8'h00;
        duty[1] = 8'hff;
        duty[2] = 8'h0f;
        duty[3] = 8'hf0;
        pol = 16'($urandom);
        latch = 16'($urandom);
        dir = 16'hffff;
        route = 16'hffff;
        mode = 2'b00;
        cks = 1'b0;
        pair = 2'b00;
        configure();
        measure();
        // Mixed routing in every chip mode
        for (int k = 0; k < 4; k++) begin
            mode = 2'(k);
            dir = 16'($urandom);
            route = 16'($urandom);
            latch = 16'($urandom);
            configure();
            measure();
        end
        // Every count clock ratio
        dir = 16'hffff;
        route = 16'hffff;
        for (int k = 0; k < 5; k++) begin
            cks = (k != 0);
            pair = 2'(k - 1);
            configure();
            measure();
        end
        stop_test();
    end
endmodule : pmops_top_test
